// file: include/bsm_pkg.sv
// Shared constants for the boundary scan mode select block
package bsm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    // Control register bit positions and reset value
    localparam int CTRL_EXTEST = 0;
    localparam int CTRL_HIZ    = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Status register bit positions
    localparam int ST_SCAN     = 0;
    localparam int ST_SECURE   = 1;
    localparam int ST_SECURED  = 2;
    localparam int ST_PATTERN  = 3;
    localparam int ST_DRIVE    = 4;
    // Startup source codes
    localparam logic [1:0] BOOT_FUSE     = 2'h0;
    localparam logic [1:0] BOOT_SERIAL   = 2'h1;
    localparam logic [1:0] BOOT_INTERNAL = 2'h2;
    // Debug security fuse codes
    localparam logic [1:0] SEC_OPEN    = 2'h0;
    localparam logic [1:0] SEC_SECURED = 2'h1;
    // Compliance pattern on compliance pins 3..0 and the factory test pin
    localparam logic [3:0] PATTERN_CPINS = 4'h8;
    localparam logic       PATTERN_FTEST = 1'h1;
    // Pin classes
    typedef enum logic [1:0] {PC_IN, PC_OUT, PC_BUFFER, PC_INOUT} bsm_class_t;
    localparam logic [1:0] PC_LINKAGE_MARK = 2'h3;
    // AHB codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;
endpackage

// file: rtl/bsm_mode_select.sv
// Test port routing between core debug and boundary scan, with scan cells
// How it works
// - Select pin high routes port to scan
// - Entry needs select, startup source, fuses
// - Off fuse zero activates secure debug
// - Reset low holds all scan off
// - Compliance pattern 10001 (pins 3..0, factory test) is needed for scan mode
// - Linkage pins get no scan cell
// - Each cell obeys its pin class
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
module bsm_mode_select #(
    parameter int PINS = 8,
    parameter logic [2*PINS-1:0] PIN_CLASS = 16'h3E4C
) (
    // Clock, reset, enable
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire logic            ce,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic [31:0]          hrdata,
    output logic                 hresp,
    // Mode pins and fuses
    input  wire logic            testPathSelect,
    input  wire logic [1:0]      bootSource,
    input  wire logic [3:0]      compliancePins,
    input  wire logic            factoryTest,
    input  wire logic [1:0]      debugSecurityFuse,
    input  wire logic            secureDebugControllerOffFuse,
    // Test port
    input  wire logic            tpShift,
    input  wire logic            tpCapture,
    input  wire logic            tpUpdate,
    input  wire logic            tpDataIn,
    output logic                 tpDataOut,
    // Core debug side
    output logic                 dbgShift,
    output logic                 dbgCapture,
    output logic                 dbgUpdate,
    output logic                 dbgDataIn,
    input  wire logic            dbgDataOut,
    // Pins
    input  wire logic [PINS-1:0] funcOut,
    input  wire logic [PINS-1:0] funcOeN,
    input  wire logic [PINS-1:0] padIn,
    output logic [PINS-1:0]      padOut,
    output logic [PINS-1:0]      padOeN
);
    logic [1:0]      ctrl_r;
    logic            scanMode_r;
    logic            wrPend_r;
    logic [7:0]      wrAddr_r;
    logic [PINS:0]   chain;
    logic [PINS-1:0] cellOut;
    logic [PINS-1:0] cellOeN;

    // Mode decode
    wire patternOk  = (bootSource == bsm_pkg::BOOT_FUSE)
                   && (compliancePins == bsm_pkg::PATTERN_CPINS)
                   && (factoryTest == bsm_pkg::PATTERN_FTEST);
    wire secureOn   = !secureDebugControllerOffFuse;
    wire secured    = secureOn && (debugSecurityFuse == bsm_pkg::SEC_SECURED);
    wire openAccess = !secureOn || (debugSecurityFuse == bsm_pkg::SEC_OPEN);
    wire scanEntry  = testPathSelect && patternOk && openAccess;
    wire drive      = scanMode_r && ctrl_r[bsm_pkg::CTRL_EXTEST];

    // Scan chain control reaches cells only in scan mode
    wire cShift   = scanMode_r && tpShift;
    wire cCapture = scanMode_r && tpCapture;
    wire cUpdate  = scanMode_r && tpUpdate;

    // Bus decode
    wire        addrTake = hsel && hready && (htrans == bsm_pkg::HTRANS_NONSEQ);
    wire [7:0]  addrOfs  = haddr[7:0];
    wire [31:0] status   = {27'h0, drive, patternOk, secured, secureOn, scanMode_r};
    wire [31:0] rdNext   = (addrOfs == bsm_pkg::OFS_CTRL)   ? {30'h0, ctrl_r} :
                           (addrOfs == bsm_pkg::OFS_STATUS) ? status : 32'h0;

    assign chain[0] = tpDataIn;

    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            localparam logic [1:0] CLS = PIN_CLASS[2*g +: 2];
            if (g % 2 == 1 && CLS == bsm_pkg::PC_LINKAGE_MARK)
            begin : g_link
                // Odd slots marked 3 are linkage: no cell, chain passes by
                assign chain[g+1]  = chain[g];
                assign cellOut[g]  = 1'b0;
                assign cellOeN[g]  = 1'b1;
                a_linkage_no_cell: assert property (@(posedge mclk)
                    disable iff (!reset_n)
                    (reset_n && ce) |=> (padOut[g] == $past(funcOut[g])))
                    else $error("linkage pin touched by scan");
            end
            else
            begin : g_cell
                bsm_scan_cell #(
                    .CLASS(bsm_pkg::bsm_class_t'(CLS))
                ) u_cell (
                    .mclk     (mclk),
                    .reset_n  (reset_n),
                    .ce       (ce),
                    .shift    (cShift),
                    .capture  (cCapture),
                    .update   (cUpdate),
                    .hiZ      (ctrl_r[bsm_pkg::CTRL_HIZ]),
                    .serialIn (chain[g]),
                    .serialOut(chain[g+1]),
                    .padIn    (padIn[g]),
                    .cellOut  (cellOut[g]),
                    .cellOeN  (cellOeN[g])
                );
            end
        end
    endgenerate

    // Linkage pins always follow the core, even when scan drives
    function automatic logic isLink(input int i);
        isLink = (i % 2 == 1) && (PIN_CLASS[2*i +: 2] == bsm_pkg::PC_LINKAGE_MARK);
    endfunction

    logic [PINS-1:0] drvMask;
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
            drvMask[i] = drive && !isLink(i);
    end

    // Mode register; reset forces debug routing
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            scanMode_r <= 1'b0;
        else if (ce)
            scanMode_r <= scanEntry;
    end

    // Test port routing
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tpDataOut  <= 1'b0;
            dbgShift   <= 1'b0;
            dbgCapture <= 1'b0;
            dbgUpdate  <= 1'b0;
            dbgDataIn  <= 1'b0;
        end
        else if (ce)
        begin
            tpDataOut  <= scanMode_r ? chain[PINS] : dbgDataOut;
            dbgShift   <= !scanMode_r && tpShift;
            dbgCapture <= !scanMode_r && tpCapture;
            dbgUpdate  <= !scanMode_r && tpUpdate;
            dbgDataIn  <= !scanMode_r && tpDataIn;
        end
    end

    // Pads: functional unless scan drives them
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            padOut <= '0;
            padOeN <= '1;
        end
        else if (ce)
        begin
            padOut <= (drvMask & cellOut) | (~drvMask & funcOut);
            padOeN <= (drvMask & cellOeN) | (~drvMask & funcOeN);
        end
    end

    // AHB-Lite slave, zero wait states; unmapped reads return zero
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r    <= bsm_pkg::CTRL_RESET;
            wrPend_r  <= 1'b0;
            wrAddr_r  <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= bsm_pkg::HRESP_OKAY;
        end
        else if (ce)
        begin
            wrPend_r <= addrTake && hwrite;
            wrAddr_r <= addrOfs;
            if (addrTake && !hwrite)
                hrdata <= rdNext;
            if (wrPend_r && wrAddr_r == bsm_pkg::OFS_CTRL)
                ctrl_r <= hwdata[1:0];
        end
    end

    // Checks
    sequence s_entryHeld;
        reset_n && ce && scanEntry ##1 ce && scanEntry;
    endsequence
    sequence s_leave;
        ce && scanMode_r && !scanEntry;
    endsequence

    a_scan_route_entry: assert property (@(posedge mclk) disable iff (!reset_n)
        s_entryHeld |=> scanMode_r && !dbgShift)
        else $error("scan entry not taken");
    a_scan_leave: assert property (@(posedge mclk) disable iff (!reset_n)
        s_leave |=> (!scanMode_r and (ce |=> tpDataOut == $past(dbgDataOut))))
        else $error("debug routing not restored");
    a_boot_source_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && bootSource != bsm_pkg::BOOT_FUSE) |=> !scanMode_r)
        else $error("scan entered with wrong startup source");
    a_secured_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && secured) |=> !scanMode_r)
        else $error("scan entered under secured access");
    a_reset_release: assert property (@(posedge mclk)
        $rose(reset_n) |-> !scanMode_r && padOeN == '1)
        else $error("state not cleared by reset");
    a_pattern_needed: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && !patternOk) |=> !scanMode_r)
        else $error("scan entered without compliance pattern");
    a_tdo_from_chain: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && scanMode_r) |=> tpDataOut == $past(chain[PINS]))
        else $error("scan data out not from chain");
    a_func_passthru: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && ce && !drive) |=> padOut == $past(funcOut) && padOeN == $past(funcOeN))
        else $error("pins disturbed outside scan drive");
endmodule // bsm_mode_select

// file: rtl/bsm_scan_cell.sv
// One boundary scan cell, shaped by its pin class
module bsm_scan_cell #(
    parameter bsm_pkg::bsm_class_t CLASS = bsm_pkg::PC_INOUT
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic ce,
    // Chain control
    input  wire logic shift,
    input  wire logic capture,
    input  wire logic update,
    input  wire logic hiZ,
    input  wire logic serialIn,
    output logic      serialOut,
    // Pin side
    input  wire logic padIn,
    output logic      cellOut,
    output logic      cellOeN
);
    logic shiftBit_r;
    logic updBit_r;
    wire  canDrive   = (CLASS != bsm_pkg::PC_IN);
    wire  canCapture = (CLASS == bsm_pkg::PC_IN) || (CLASS == bsm_pkg::PC_INOUT);
    wire  capValue   = canCapture ? padIn : updBit_r;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shiftBit_r <= 1'b0;
            updBit_r   <= 1'b0;
        end
        else if (ce)
        begin
            if (capture)
                shiftBit_r <= capValue;
            else if (shift)
                shiftBit_r <= serialIn;
            if (update && canDrive)
                updBit_r <= shiftBit_r;
        end
    end

    assign serialOut = shiftBit_r;
    assign cellOut   = canDrive ? updBit_r : 1'b0;
    // Buffers ignore the high-Z control; input-only cells never drive
    assign cellOeN   = !canDrive ? 1'b1 :
                       (CLASS == bsm_pkg::PC_BUFFER) ? 1'b0 : hiZ;

    a_input_no_drive: assert property (@(posedge mclk) disable iff (!reset_n)
        (CLASS == bsm_pkg::PC_IN) |-> cellOeN)
        else $error("input-only cell drives its pin");
    a_buffer_two_state: assert property (@(posedge mclk) disable iff (!reset_n)
        (CLASS == bsm_pkg::PC_BUFFER) |-> !cellOeN)
        else $error("buffer cell left its pin undriven");
endmodule // bsm_scan_cell

// file: testbench/bsm_tool.sv
// Boundary scan test tool model: test port controls and mode pins
module bsm_tool (
    // Clock
    input  wire logic  mclk,
    // Test port
    output logic       tpShift,
    output logic       tpCapture,
    output logic       tpUpdate,
    output logic       tpDataIn,
    // Mode pins
    output logic       testPathSelect,
    output logic [1:0] bootSource,
    output logic [3:0] compliancePins,
    output logic       factoryTest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {tpShift, tpCapture, tpUpdate, tpDataIn} = 4'h0;
        {testPathSelect, bootSource, compliancePins, factoryTest} = 8'h00;
    end
    // Held as levels until the next setMode call, never pulsed
    task automatic setMode(input logic [7:0] m);
        @(posedge mclk);
        {testPathSelect, bootSource, compliancePins, factoryTest} <= m;
    endtask
    task automatic step(input logic s, input logic c, input logic u, input logic d);
        @(posedge mclk);
        {tpShift, tpCapture, tpUpdate, tpDataIn} <= {s, c, u, d};
    endtask
    // Six cells only: linkage pins sit outside the chain
    task automatic shiftIn(input logic [5:0] b);
        for (int i = 0; i < 6; i++)
            step(1'h1, 1'h0, 1'h0, b[i]);
        // Released data line shows the inverse, not a stale bit
        step(1'h0, 1'h0, 1'h1, ~b[5]);
        step(1'h0, 1'h0, 1'h0, ~b[5]);
    endtask
endmodule // bsm_tool

// file: testbench/tb.sv
// Self-checking bench for the boundary scan mode select block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, reset_n, ce, hsel, hwrite, hreadyout, hresp, tpDataOut;
    logic        dbgShift, dbgCapture, dbgUpdate, dbgDataIn, dbgDataOut, offF;
    logic        tpShift, tpCapture, tpUpdate, tpDataIn, testPathSelect, factoryTest;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, secF, bootSource;
    logic [3:0]  compliancePins;
    logic [2:0]  hsize;
    logic [7:0]  funcOut, funcOeN, padIn, padOut, padOeN;
    logic [11:0] cases [9];
    int          errors, total_checks;

    bsm_mode_select dut (.mclk, .reset_n, .ce, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .testPathSelect, .bootSource, .compliancePins, .factoryTest,
        .debugSecurityFuse(secF), .secureDebugControllerOffFuse(offF),
        .tpShift, .tpCapture, .tpUpdate, .tpDataIn, .tpDataOut, .dbgShift,
        .dbgCapture, .dbgUpdate, .dbgDataIn, .dbgDataOut, .funcOut, .funcOeN,
        .padIn, .padOut, .padOeN);
    bsm_tool tool (.mclk, .tpShift, .tpCapture, .tpUpdate, .tpDataIn,
        .testPathSelect, .bootSource, .compliancePins, .factoryTest);

    always #5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {hsel, htrans, hwrite, haddr} <= {1'h1, bsm_pkg::HTRANS_NONSEQ, w, 24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'h1);
        {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
        do @(posedge mclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk(hresp, bsm_pkg::HRESP_OKAY);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_regs;
        chk(padOeN, 8'hFF);
        ahb(1'h0, bsm_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        ahb(1'h1, bsm_pkg::OFS_CTRL, 32'h3);
        ahb(1'h0, bsm_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h3);
        ahb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        // Enable low must freeze the pads even though the core moves
        ce      <= 1'h0;
        funcOut <= 8'h3C;
        repeat (3) @(posedge mclk);
        chk(padOut, 8'hA5);
        ce <= 1'h1;
        repeat (2) @(posedge mclk);
        chk(padOut, 8'h3C);
        funcOut <= 8'hA5;
        $display("test regs done");
    endtask
    task automatic t_modes;
        foreach (cases[i])
        begin
            tool.setMode(cases[i][11:4]);
            {secF, offF} <= cases[i][3:1];
            repeat (3) @(posedge mclk);
            ahb(1'h0, bsm_pkg::OFS_STATUS, 32'h0);
            chk(rd[1:0], {~cases[i][1], cases[i][0]});
        end
        $display("test modes done");
    endtask
    task automatic t_route;
        tool.setMode(8'h11);
        dbgDataOut <= 1'h1;
        ahb(1'h1, bsm_pkg::OFS_CTRL, 32'h1);
        tool.step(1'h1, 1'h1, 1'h1, 1'h1);
        repeat (3) @(posedge mclk);
        chk({padOut, padOeN}, {funcOut, funcOeN});
        chk({dbgShift, dbgCapture, dbgUpdate, dbgDataIn, tpDataOut}, 5'h1F);
        tool.setMode(8'h91);
        repeat (3) @(posedge mclk);
        chk({dbgShift, dbgCapture, dbgUpdate, dbgDataIn}, 4'h0);
        tool.step(1'h0, 1'h0, 1'h0, 1'h0);
        dbgDataOut <= 1'h0;
        $display("test route done");
    endtask
    task automatic t_chain;
        for (int v = 1; v >= 0; v--)
        begin
            padIn <= {v[0], 7'h2A};
            tool.step(1'h0, 1'h1, 1'h0, 1'h0);
            tool.step(1'h0, 1'h0, 1'h0, 1'h1);
            repeat (3) @(posedge mclk);
            chk(tpDataOut, v[0]);
        end
        tool.shiftIn(6'b100101);
        repeat (3) @(posedge mclk);
        chk({padOut[4:3], padOeN[4:3]}, 4'b1000);
        chk({padOut[5], padOut[1], padOeN[5], padOeN[1]}, 4'b1001);
        ahb(1'h1, bsm_pkg::OFS_CTRL, 32'h3);
        repeat (3) @(posedge mclk);
        chk(padOeN[4:3], 2'b01);
        $display("test chain done");
    endtask
    task automatic t_reset;
        reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        chk({padOeN, tpDataOut}, {8'hFF, 1'h0});
        reset_n <= 1'h1;
        repeat (3) @(posedge mclk);
        ahb(1'h0, bsm_pkg::OFS_STATUS, 32'h0);
        chk(rd[0], 1'h1);
        chk({padOut, padOeN}, {funcOut, funcOeN});
        $display("test reset done");
    endtask

    initial
    begin
        cases = '{12'h911, 12'h110, 12'hB10, 12'hD10, 12'h930, 12'h900,
                  12'h914, 12'h918, 12'h917};
        {mclk, reset_n, hsel, hwrite, haddr, hwdata, htrans} = '0;
        {secF, offF, dbgDataOut, padIn} = '0;
        ce = 1'h1;
        {hsize, funcOut, funcOeN} = {3'h2, 8'hA5, 8'h5A};
        repeat (16) @(posedge mclk);
        reset_n <= 1'h1;
        t_regs();
        t_modes();
        t_route();
        t_chain();
        t_reset();
        tally_and_finish();
    end
    // Whole run is under 150 cycles; this is far beyond it
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule // tb
